// File: hdl/dmss_divider.sv
// sequential restoring divider, one quotient bit per clock
`timescale 1ns/10ps
`default_nettype none
module dmss_divider #(
    parameter int W = 16
) (
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    input  wire logic         start_in,
    input  wire logic [W-1:0] dividend_in,
    input  wire logic [W-1:0] divisor_in,
    output logic              done_out,
    output logic [W-1:0]      quotient_out
);
    localparam int CW = $clog2(W + 1);

    logic [W-1:0]  rem;
    logic [W-1:0]  quo;
    logic [W-1:0]  den;
    logic [CW-1:0] cnt;
    logic          busy;
    logic          done;
    logic [W-1:0]  next_rem;
    logic [W-1:0]  next_quo;
    logic [W-1:0]  next_den;
    logic [CW-1:0] next_cnt;
    logic          next_busy;
    logic          next_done;
    logic [W:0]    shifted;

    // a zero divisor leaves an all-ones quotient, read as saturation
    always_comb begin
        shifted   = {rem, quo[W-1]};
        next_rem  = rem;
        next_quo  = quo;
        next_den  = den;
        next_cnt  = cnt;
        next_busy = busy;
        next_done = 1'b0;
        if (start_in) begin
            next_rem  = '0;
            next_quo  = dividend_in;
            next_den  = divisor_in;
            next_cnt  = '0;
            next_busy = 1'b1;
        end else if (busy) begin
            if (shifted >= {1'b0, den}) begin
                next_rem = W'(shifted - {1'b0, den});
                next_quo = {quo[W-2:0], 1'b1};
            end else begin
                next_rem = shifted[W-1:0];
                next_quo = {quo[W-2:0], 1'b0};
            end
            next_cnt = CW'(cnt + 1'b1);
            if (cnt == CW'(W - 1)) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rem  <= '0;
            quo  <= '0;
            den  <= '0;
            cnt  <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            rem  <= next_rem;
            quo  <= next_quo;
            den  <= next_den;
            cnt  <= next_cnt;
            busy <= next_busy;
            done <= next_done;
        end
    end

    assign done_out     = done;
    assign quotient_out = quo;
endmodule
`default_nettype wire

// File: hdl/dmss_lerp.sv
// linear blend between two 8-bit levels by a fraction of 256
`timescale 1ns/10ps
`default_nettype none
module dmss_lerp (
    input  wire logic [7:0] from_in,
    input  wire logic [7:0] to_in,
    input  wire logic [8:0] frac_in,
    output logic [7:0]      value_out
);
    logic signed [9:0]  diff;
    logic signed [19:0] prod;
    logic signed [10:0] sum;

    // frac 256 lands exactly on to_in, so no overshoot past either end for frac 0 to 256
    always_comb begin
        diff      = $signed({2'b00, to_in}) - $signed({2'b00, from_in});
        prod      = diff * $signed({1'b0, frac_in});
        sum       = $signed({3'b000, from_in}) + prod[18:8];
        value_out = sum[7:0];
    end
endmodule
`default_nettype wire

// File: hdl/dmss_pkg.sv
// shared constants and types for the dual motor steering shaper
package dmss_pkg;

    // register port geometry
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;

    // writable settings, stored by index
    localparam logic [3:0] REG_CONTROL_MODE   = 4'h0;
    localparam logic [3:0] REG_MOTOR_SELECT   = 4'h1;
    localparam logic [3:0] REG_POT_LOW_VOLT   = 4'h2;
    localparam logic [3:0] REG_POT_CENTER     = 4'h3;
    localparam logic [3:0] REG_POT_HIGH_VOLT  = 4'h4;
    localparam logic [3:0] REG_CUTBACK_PCT    = 4'h5;
    localparam logic [3:0] REG_ANGLE_ONE      = 4'h6;
    localparam logic [3:0] REG_ANGLE_TWO      = 4'h7;
    localparam logic [3:0] REG_ANGLE_THREE    = 4'h8;
    localparam logic [3:0] REG_SPEED_ONE      = 4'h9;
    localparam logic [3:0] REG_SPEED_TWO      = 4'ha;
    localparam logic [3:0] REG_SPEED_THREE    = 4'hb;
    localparam int         CFG_COUNT          = 12;
    // read-only views of the block's own state
    localparam logic [3:0] REG_STATUS         = 4'hc;
    localparam logic [3:0] REG_STEER_PCT      = 4'hd;

    // reset values, indexed like the settings above
    localparam logic [7:0] CFG_RESET [CFG_COUNT] = '{
        8'h00, 8'h00, 8'h00, 8'h19, 8'h32, 8'h0a,
        8'h1e, 8'h3c, 8'h5a, 8'h40, 8'h20, 8'h40};

    // status register field positions
    localparam int ST_ACTIVE_BIT    = 7;
    localparam int ST_INNER_BIT     = 6;
    localparam int ST_REVERSE_BIT   = 5;
    localparam int ST_FREEWHEEL_BIT = 4;

    // setting encodings
    localparam logic [7:0] MODE_TORQUE = 8'h01;
    localparam logic [7:0] SEL_LEFT    = 8'h01;
    localparam logic [7:0] SEL_RIGHT   = 8'h02;

    // percentage and fraction scaling
    localparam logic [15:0] PCT_FULL   = 16'h0064;
    localparam int          FRAC_BITS  = 8;
    localparam logic [8:0]  FRAC_ONE   = 9'h100;

    // control loop rate
    localparam int CLK_KHZ        = 25000;
    localparam int LOOP_PERIOD_US = 1000;
    localparam int LOOP_CYCLES    = (LOOP_PERIOD_US * CLK_KHZ) / 1000;

    typedef enum logic [2:0] {
        ZONE_DEAD = 3'b000,
        ZONE_CUT  = 3'b001,
        ZONE_FREE = 3'b010,
        ZONE_REV  = 3'b011,
        ZONE_FULL = 3'b100
    } dmss_zone_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PCT  = 2'b01,
        ST_FRAC = 2'b10,
        ST_OUT  = 2'b11
    } dmss_state_t;

endpackage

// File: hdl/dmss_shaper.sv
// dual motor steering shaper: speed and torque targets for one motor
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dmss_shaper
    import dmss_pkg::*;
#(
    parameter int LOOP_CYCLES_P = dmss_pkg::LOOP_CYCLES
) (
    input  wire logic                        clk_in,
    input  wire logic                        rstn_in,
    input  wire logic [dmss_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [dmss_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    output logic [dmss_pkg::DATA_W-1:0]      rdata_out,
    input  wire logic [7:0]                  pot_volt_in,
    input  wire logic [7:0]                  speed_demand_in,
    input  wire logic [7:0]                  torque_demand_in,
    output logic [7:0]                       speed_limit_out,
    output logic [7:0]                       torque_limit_out,
    output logic                             reverse_out,
    output logic                             freewheel_out,
    output logic                             shaping_active_out,
    output logic                             inner_motor_out,
    output logic [7:0]                       steer_pct_out,
    output logic                             update_out
);
    import dmss_pkg::*;

    localparam int TW = $clog2(LOOP_CYCLES_P + 1);

    // settings and register read path
    logic [7:0]    cfg [CFG_COUNT];
    logic [7:0]    next_cfg [CFG_COUNT];
    logic [7:0]    rdata;
    logic [7:0]    next_rdata;
    // loop rate divider
    logic [TW-1:0] tick_cnt;
    logic [TW-1:0] next_tick_cnt;
    logic          tick;
    // sample sequencer
    dmss_state_t   state;
    dmss_state_t   next_state;
    logic [7:0]    pot;
    logic [7:0]    next_pot;
    logic [7:0]    dem_spd;
    logic [7:0]    next_dem_spd;
    logic [7:0]    dem_trq;
    logic [7:0]    next_dem_trq;
    logic [7:0]    mag;
    logic [7:0]    next_mag;
    logic          neg;
    logic          next_neg;
    logic [8:0]    frac;
    logic [8:0]    next_frac;
    // registered results
    logic [7:0]    spd_q;
    logic [7:0]    next_spd_q;
    logic [7:0]    trq_q;
    logic [7:0]    next_trq_q;
    logic          rev_q;
    logic          next_rev_q;
    logic          free_q;
    logic          next_free_q;
    logic          active_q;
    logic          next_active_q;
    logic          inner_q;
    logic          next_inner_q;
    dmss_zone_t    zone_q;
    dmss_zone_t    next_zone_q;
    logic [7:0]    pct_q;
    logic [7:0]    next_pct_q;
    logic          upd_q;
    logic          next_upd_q;
    // divider and blend wiring
    logic          div_start;
    logic [15:0]   div_num;
    logic [15:0]   div_den;
    logic          div_done;
    logic [15:0]   div_quo;
    logic [7:0]    spd_from;
    logic [7:0]    spd_to;
    logic [7:0]    trq_from;
    logic [7:0]    trq_to;
    logic [7:0]    spd_blend;
    logic [7:0]    trq_blend;
    // combinational decode of the current sample
    logic          active;
    logic          inner;
    dmss_zone_t    zone;
    logic [7:0]    seg_lo;
    logic [7:0]    seg_hi;
    logic [7:0]    half_spd3;
    logic [7:0]    half_trq;

    dmss_divider #(.W(16)) u_div (
        .clk_in       (clk_in),
        .rstn_in      (rstn_in),
        .start_in     (div_start),
        .dividend_in  (div_num),
        .divisor_in   (div_den),
        .done_out     (div_done),
        .quotient_out (div_quo)
    );

    dmss_lerp u_spd_lerp (
        .from_in   (spd_from),
        .to_in     (spd_to),
        .frac_in   (frac),
        .value_out (spd_blend)
    );

    dmss_lerp u_trq_lerp (
        .from_in   (trq_from),
        .to_in     (trq_to),
        .frac_in   (frac),
        .value_out (trq_blend)
    );

    // register writes and one-cycle-late reads; unmapped reads give zero
    always_comb begin
        next_cfg   = cfg;
        next_rdata = 8'h00;
        if (wr_in && (addr_in < ADDR_W'(CFG_COUNT))) begin
            next_cfg[addr_in] = wdata_in;
        end
        if (rd_in) begin
            if (addr_in < ADDR_W'(CFG_COUNT)) begin
                next_rdata = cfg[addr_in];
            end else if (addr_in == REG_STATUS) begin
                next_rdata = 8'h00;
                next_rdata[ST_ACTIVE_BIT]    = active_q;
                next_rdata[ST_INNER_BIT]     = inner_q;
                next_rdata[ST_REVERSE_BIT]   = rev_q;
                next_rdata[ST_FREEWHEEL_BIT] = free_q;
                next_rdata[2:0]              = zone_q;
            end else if (addr_in == REG_STEER_PCT) begin
                next_rdata = pct_q;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg   <= CFG_RESET;
            rdata <= 8'h00;
        end else begin
            cfg   <= next_cfg;
            rdata <= next_rdata;
        end
    end

    // control loop tick, a one-cycle enable
    always_comb begin
        tick          = (tick_cnt == TW'(LOOP_CYCLES_P - 1));
        next_tick_cnt = tick ? '0 : TW'(tick_cnt + 1'b1);
    end

    // decode of mode, side and zone from the captured steering magnitude
    always_comb begin
        active = (cfg[REG_CONTROL_MODE] == MODE_TORQUE)
              && ((cfg[REG_MOTOR_SELECT] == SEL_LEFT)
              ||  (cfg[REG_MOTOR_SELECT] == SEL_RIGHT));
        inner  = ((cfg[REG_MOTOR_SELECT] == SEL_LEFT) && neg)
              || ((cfg[REG_MOTOR_SELECT] == SEL_RIGHT) && !neg);
        if (mag <= cfg[REG_CUTBACK_PCT]) begin
            zone = ZONE_DEAD;
        end else if (mag <= cfg[REG_ANGLE_ONE]) begin
            zone = ZONE_CUT;
        end else if (mag <= cfg[REG_ANGLE_TWO]) begin
            zone = ZONE_FREE;
        end else if (mag <= cfg[REG_ANGLE_THREE]) begin
            zone = ZONE_REV;
        end else begin
            zone = ZONE_FULL;
        end
        // breakpoints bounding the current segment
        seg_lo = 8'h00;
        seg_hi = 8'h00;
        if (zone == ZONE_CUT && inner) begin
            seg_lo = cfg[REG_CUTBACK_PCT];
            seg_hi = cfg[REG_ANGLE_ONE];
        end else if ((zone == ZONE_CUT || zone == ZONE_FREE) && !inner) begin
            seg_lo = cfg[REG_CUTBACK_PCT];
            seg_hi = cfg[REG_ANGLE_TWO];
        end else if (zone == ZONE_REV) begin
            seg_lo = cfg[REG_ANGLE_TWO];
            seg_hi = cfg[REG_ANGLE_THREE];
        end
        half_spd3 = {1'b0, cfg[REG_SPEED_THREE][7:1]};
        half_trq  = {1'b0, dem_trq[7:1]};
    end

    // blend end points per zone; equal ends where the level is flat
    always_comb begin
        spd_from = dem_spd;
        spd_to   = dem_spd;
        trq_from = dem_trq;
        trq_to   = dem_trq;
        if (active && inner) begin
            case (zone)
                ZONE_DEAD: begin
                    spd_to = dem_spd;
                end
                ZONE_CUT: begin
                    spd_to = cfg[REG_SPEED_ONE];
                    trq_to = 8'h00;
                end
                ZONE_FREE: begin
                    spd_from = cfg[REG_SPEED_ONE];
                    spd_to   = cfg[REG_SPEED_ONE];
                    trq_from = 8'h00;
                    trq_to   = 8'h00;
                end
                ZONE_REV: begin
                    spd_from = cfg[REG_SPEED_TWO];
                    spd_to   = half_spd3;
                    trq_from = 8'h00;
                    trq_to   = half_trq;
                end
                ZONE_FULL: begin
                    spd_from = half_spd3;
                    spd_to   = half_spd3;
                    trq_from = half_trq;
                    trq_to   = half_trq;
                end
                default: begin
                    spd_to = dem_spd;
                end
            endcase
        end else if (active) begin
            case (zone)
                ZONE_CUT, ZONE_FREE: begin
                    spd_to = cfg[REG_SPEED_THREE];
                end
                ZONE_REV: begin
                    spd_from = cfg[REG_SPEED_THREE];
                    spd_to   = half_spd3;
                end
                ZONE_FULL: begin
                    spd_from = half_spd3;
                    spd_to   = half_spd3;
                end
                default: begin
                    spd_to = dem_spd;
                end
            endcase
        end
    end

    // sample sequencer: percent divide, segment divide, then outputs
    always_comb begin
        next_state    = state;
        next_pot      = pot;
        next_dem_spd  = dem_spd;
        next_dem_trq  = dem_trq;
        next_mag      = mag;
        next_neg      = neg;
        next_frac     = frac;
        next_spd_q    = spd_q;
        next_trq_q    = trq_q;
        next_rev_q    = rev_q;
        next_free_q   = free_q;
        next_active_q = active_q;
        next_inner_q  = inner_q;
        next_zone_q   = zone_q;
        next_pct_q    = pct_q;
        next_upd_q    = 1'b0;
        div_start     = 1'b0;
        div_num       = 16'h0000;
        div_den       = 16'h0000;
        case (state)
            ST_IDLE: begin
                if (tick) begin
                    next_pot     = pot_volt_in;
                    next_dem_spd = speed_demand_in;
                    next_dem_trq = torque_demand_in;
                    next_state   = ST_PCT;
                    div_start    = 1'b1;
                    // zero span saturates to full lock
                    if (pot_volt_in >= cfg[REG_POT_CENTER]) begin
                        next_neg = 1'b0;
                        div_num  = 16'(pot_volt_in - cfg[REG_POT_CENTER])
                                 * PCT_FULL;
                        div_den  = 16'(cfg[REG_POT_HIGH_VOLT]
                                 - cfg[REG_POT_CENTER]);
                    end else begin
                        next_neg = 1'b1;
                        div_num  = 16'(cfg[REG_POT_CENTER] - pot_volt_in)
                                 * PCT_FULL;
                        div_den  = 16'(cfg[REG_POT_CENTER]
                                 - cfg[REG_POT_LOW_VOLT]);
                    end
                end
            end
            ST_PCT: begin
                if (div_done) begin
                    next_mag = (div_quo > PCT_FULL) ? PCT_FULL[7:0]
                                                    : div_quo[7:0];
                    next_state = ST_FRAC;
                end
            end
            ST_FRAC: begin
                // start the segment divide once on entry, then take the clamped fraction
                if (!div_done && (frac != FRAC_ONE + 9'h001)) begin
                    div_start = 1'b1;
                    div_num   = 16'(mag - seg_lo) << FRAC_BITS;
                    div_den   = 16'(seg_hi - seg_lo);
                    next_frac = FRAC_ONE + 9'h001;
                end else if (div_done) begin
                    next_frac  = (div_quo > 16'(FRAC_ONE)) ? FRAC_ONE
                                                           : div_quo[8:0];
                    next_state = ST_OUT;
                end
            end
            ST_OUT: begin
                next_spd_q    = spd_blend;
                next_trq_q    = trq_blend;
                next_active_q = active;
                next_inner_q  = active && inner;
                next_rev_q    = active && inner
                             && (zone == ZONE_REV || zone == ZONE_FULL);
                next_free_q   = active && inner && (zone == ZONE_FREE);
                next_zone_q   = zone;
                next_pct_q    = neg ? 8'(-mag) : mag;
                next_upd_q    = 1'b1;
                next_frac     = 9'h000;
                next_state    = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_cnt <= '0;
            state    <= ST_IDLE;
            pot      <= 8'h00;
            dem_spd  <= 8'h00;
            dem_trq  <= 8'h00;
            mag      <= 8'h00;
            neg      <= 1'b0;
            frac     <= 9'h000;
            spd_q    <= 8'h00;
            trq_q    <= 8'h00;
            rev_q    <= 1'b0;
            free_q   <= 1'b0;
            active_q <= 1'b0;
            inner_q  <= 1'b0;
            zone_q   <= ZONE_DEAD;
            pct_q    <= 8'h00;
            upd_q    <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            state    <= next_state;
            pot      <= next_pot;
            dem_spd  <= next_dem_spd;
            dem_trq  <= next_dem_trq;
            mag      <= next_mag;
            neg      <= next_neg;
            frac     <= next_frac;
            spd_q    <= next_spd_q;
            trq_q    <= next_trq_q;
            rev_q    <= next_rev_q;
            free_q   <= next_free_q;
            active_q <= next_active_q;
            inner_q  <= next_inner_q;
            zone_q   <= next_zone_q;
            pct_q    <= next_pct_q;
            upd_q    <= next_upd_q;
        end
    end

    // all outputs straight from flip-flops
    assign rdata_out          = rdata;
    assign speed_limit_out    = spd_q;
    assign torque_limit_out   = trq_q;
    assign reverse_out        = rev_q;
    assign freewheel_out      = free_q;
    assign shaping_active_out = active_q;
    assign inner_motor_out    = inner_q;
    assign steer_pct_out      = pct_q;
    assign update_out         = upd_q;
endmodule
`default_nettype wire

// File: tb/dmss_far.sv
// far side: steering pot reading plus speed and torque demand
`timescale 1ns/10ps
`default_nettype none
module dmss_far (
    input  wire logic        clk_in,
    input  wire logic [23:0] set_in,
    output logic      [23:0] val_out
);
    // one edge late, like a sampled analog front end
    always_ff @(posedge clk_in) begin
        val_out <= set_in;
    end
endmodule
`default_nettype wire

// File: tb/dmss_shaper_sva.sv
// port assertions for the steering shaper
`timescale 1ns/10ps
`default_nettype none
module dmss_shaper_chk
    import dmss_pkg::*;
(
    input wire logic       clk_in,
    input wire logic       rstn_in,
    input wire logic [3:0] addr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic [7:0] speed_limit_out,
    input wire logic [7:0] torque_limit_out,
    input wire logic       reverse_out,
    input wire logic       freewheel_out,
    input wire logic       shaping_active_out,
    input wire logic       inner_motor_out,
    input wire logic [7:0] steer_pct_out,
    input wire logic       update_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    property p_pulse; update_out |=> !update_out; endproperty
    a_pulse: assert property (p_pulse) else $error("long update");
    property p_hold; $changed(speed_limit_out) || $changed(torque_limit_out)
        |-> update_out; endproperty
    a_hold: assert property (p_hold) else $error("stray change");
    property p_byp; !shaping_active_out
        |-> !(reverse_out || freewheel_out || inner_motor_out); endproperty
    a_byp: assert property (p_byp) else $error("bypass flags");
    property p_free; freewheel_out |-> torque_limit_out == 8'h00; endproperty
    a_free: assert property (p_free) else $error("freewheel torque");
    property p_inner; reverse_out || freewheel_out |-> inner_motor_out;
    endproperty
    a_inner: assert property (p_inner) else $error("outer flagged");
    property p_idle; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data idle");
    property p_pct; $signed(steer_pct_out) <= 100
        && $signed(steer_pct_out) >= -100; endproperty
    a_pct: assert property (p_pct) else $error("percent range");
    property p_stat; rd_in && addr_in == REG_STATUS |=> rdata_out[7:4] ==
        {$past(shaping_active_out), $past(inner_motor_out),
         $past(reverse_out), $past(freewheel_out)}; endproperty
    a_stat: assert property (p_stat) else $error("status view");
endmodule
bind dmss_shaper dmss_shaper_chk u_chk (.*);
`default_nettype wire

// File: tb/dmss_shaper_test.sv
// self-checking bench for the steering shaper
`timescale 1ns/10ps
`default_nettype none
module dmss_shaper_test;
    import dmss_pkg::*;
    logic clk_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0, rv, fw, act, inr, upd;
    logic [3:0] addr_in = 0;
    logic [7:0] wdata_in = 0, rdata_out, spd, trq, pct;
    logic [23:0] set = 0, val;
    logic [31:0] lf = 32'h1cbe;
    int cf[12], n_mismatch = 0, checked = 0, ep, es, et, er, ef, ei, ea, ez;
    always #20 clk_in = ~clk_in;
    dmss_far u_far (.clk_in(clk_in), .set_in(set), .val_out(val));
    dmss_shaper #(.LOOP_CYCLES_P(64)) u_dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .pot_volt_in(val[7:0]),
        .speed_demand_in(val[15:8]), .torque_demand_in(val[23:16]),
        .speed_limit_out(spd), .torque_limit_out(trq), .reverse_out(rv),
        .freewheel_out(fw), .shaping_active_out(act),
        .inner_motor_out(inr), .steer_pct_out(pct), .update_out(upd));
    function automatic logic [31:0] nx(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // floor blend, so negative slopes round down like the hardware
    function automatic int bl(int a, int b, int m, int lo, int hi);
        int f;
        f = (m - lo) * 256 / (hi - lo);
        f = f > 256 ? 256 : f;
        return a + (((b - a) * f) >>> 8);
    endfunction
    task automatic model(int p, int d, int t);
        int m, is, it, os;
        ep = p >= cf[3] ? (p - cf[3]) * 100 / (cf[4] - cf[3])
                        : -((cf[3] - p) * 100 / (cf[3] - cf[2]));
        ep = ep > 100 ? 100 : ep < -100 ? -100 : ep;
        m = ep < 0 ? -ep : ep;
        ez = m <= cf[5] ? 0 : m <= cf[6] ? 1 : m <= cf[7] ? 2
            : m <= cf[8] ? 3 : 4;
        ea = cf[0] == 1 && (cf[1] == 1 || cf[1] == 2);
        ei = ea && (cf[1] == 1 ? ep < 0 : ep >= 0);
        is = ez == 0 ? d : ez == 1 ? bl(d, cf[9], m, cf[5], cf[6]) : ez == 2
            ? cf[9] : ez == 3 ? bl(cf[10], cf[11] / 2, m, cf[7], cf[8])
            : cf[11] / 2;
        it = ez == 0 ? t : ez == 1 ? bl(t, 0, m, cf[5], cf[6]) : ez == 2 ? 0
            : ez == 3 ? bl(0, t / 2, m, cf[7], cf[8]) : t / 2;
        os = ez == 0 ? d : ez < 3 ? bl(d, cf[11], m, cf[5], cf[7]) : ez == 3
            ? bl(cf[11], cf[11] / 2, m, cf[7], cf[8]) : cf[11] / 2;
        es = !ea ? d : ei ? is : os;
        et = ei ? it : t;
        er = ei && ez >= 3;
        ef = ei && ez == 2;
    endtask
    task automatic cmp(string n, logic [7:0] g, int e);
        checked++;
        if (g !== 8'(e)) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", n, 8'(e), g);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        if (a < 12) cf[a] = v;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd(logic [3:0] a, output logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
    endtask
    // bounded wait for the update pulse; outputs settle with it
    task automatic wt();
        @(posedge clk_in);
        #1;
        for (int n = 0; n < 200 && upd !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
        end
        // a missing update is a failure, not a silent pass-through
        if (upd !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] update exp 1 got %b", upd);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #1000000;
        n_mismatch++;
        conclude();
    end
    initial begin
        logic [7:0] v;
        int p, d, t, sw;
        repeat (4) @(posedge clk_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            cf[i] = CFG_RESET[i];
            rd(4'(i), v);
            cmp("reset", v, cf[i]);
        end
        wr(4'he, 8'h55);
        rd(4'he, v);
        cmp("unmapped", v, 0);
        // torque+left, torque+right, other mode, select 0, select 3
        for (int k = 0; k < 5; k++) begin
            wt();
            wr(REG_CONTROL_MODE, k == 2 ? 8'h00 : 8'h01);
            wr(REG_MOTOR_SELECT, 8'(k == 3 ? 0 : k == 4 ? 3 : k % 2 + 1));
            wr(REG_CUTBACK_PCT, k[0] ? 8'h0c : 8'h0a);
            for (int j = 0; j < 12; j++) begin
                lf = nx(lf);
                p = lf % 61;
                d = lf[15:8];
                t = lf[23:16];
                @(posedge clk_in);
                set <= {8'(t), 8'(d), 8'(p)};
                // the first update may come from a tick before the new inputs
                wt();
                wt();
                model(p, d, t);
                cmp("speed", spd, es);
                cmp("torque", trq, et);
                cmp("reverse", {7'h0, rv}, er);
                cmp("freewheel", {7'h0, fw}, ef);
                cmp("inner", {7'h0, inr}, ei);
                cmp("active", {7'h0, act}, ea);
                cmp("steer", pct, ep);
                if (ea) begin
                    rd(REG_STEER_PCT, v);
                    cmp("percent", v, ep);
                    rd(REG_STATUS, v);
                    sw = ea * 128 + ei * 64 + er * 32 + ef * 16 + ez;
                    cmp("status", v, sw);
                end
            end
        end
        conclude();
    end
endmodule
`default_nettype wire
